//--- logic/hpt_burst_ctrl.sv
`timescale 1ns/100ps
module hpt_burst_ctrl #(
  parameter int TIMER_ID = 0,
  parameter int CAL_LEN = 16,
  parameter int CAL_BASE = 1024
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [hpt_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [hpt_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic timer_run,
  input wire logic [hpt_pkg::NTMR-1:0] cnt_rst,
  input wire logic [hpt_pkg::NTMR-1:0][3:0] cmp_evt,
  input wire logic [hpt_pkg::NTMR-1:0] chan1_pre_output,
  input wire logic [hpt_pkg::NEVT-1:0] conditioned_ext_event,
  input wire logic update_evt,
  input wire logic [30:0] burst_trig_in,
  input wire logic [9:0] burst_src_in,
  input wire logic [1:0] chan_pre_output,
  output logic [hpt_pkg::NEVT-1:0] filt_event_out,
  output logic [hpt_pkg::NEVT-1:0] filt_timeout_out,
  output logic [3:0] dac_request_out,
  output logic dll_cal_active,
  output logic [1:0] burst_pre_output,
  output logic burst_period_irq,
  output logic burst_active
);

  localparam int CW = hpt_pkg::CW;
  localparam int NE = hpt_pkg::NEVT;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    hpt_pkg::hpt_evgrp_t [1:0] evc;
    logic [hpt_pkg::NTMR-1:0][3:0] ivl;
    logic [NE-1:0] pend;
    logic [NE-1:0] seen;
    logic [NE-1:0] wprev;
    logic [NE-1:0] evo;
    logic [NE-1:0] tmo;
    hpt_pkg::hpt_tctl_t tc;
    logic [3:0] dac;
    hpt_pkg::hpt_dll_t dl;
    logic [CW-1:0] calc;
    logic [CW-1:0] perc;
    hpt_pkg::hpt_bctl_t bc;
    logic ie;
    logic pf;
    logic lock;
    logic run;
    logic entered;
    logic en_prev;
    logic irq;
    logic [CW-1:0] idle_sh;
    logic [CW-1:0] per_sh;
    logic [CW-1:0] idle_act;
    logic [CW-1:0] per_act;
    logic [CW-1:0] cnt;
    logic [CW-1:0] psc;
    logic [30:0] trg;
    logic [9:0] sprev;
    logic [1:0] pre;
  } hpt_state_t;

  hpt_state_t st_reg;
  hpt_state_t st_next;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [hpt_pkg::AW-1:0] a);
    case (a)
      hpt_pkg::A_FILT_LO, hpt_pkg::A_FILT_HI, hpt_pkg::A_TCTL,
      hpt_pkg::A_DLL, hpt_pkg::A_BCTL, hpt_pkg::A_BIDLE, hpt_pkg::A_BPER,
      hpt_pkg::A_BTRIG, hpt_pkg::A_BSTAT, hpt_pkg::A_BCNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Register read view; strobe-type bits always read zero
  function automatic logic [31:0] rdreg(input hpt_state_t s, input logic [hpt_pkg::AW-1:0] a);
    hpt_pkg::hpt_bstat_t bs;
    bs = '{burst_period_irq_en: s.ie, burst_period_flag_clr: 1'b0, burst_period_flag: s.pf};
    case (a)
      hpt_pkg::A_FILT_LO: rdreg = 32'(s.evc[0]);
      hpt_pkg::A_FILT_HI: rdreg = 32'(s.evc[1]);
      hpt_pkg::A_TCTL: rdreg = 32'(s.tc);
      hpt_pkg::A_DLL: rdreg = {17'h00000, hpt_pkg::HPCK_MULT, 3'h0, s.dl};
      hpt_pkg::A_BCTL: rdreg = 32'(s.bc);
      hpt_pkg::A_BIDLE: rdreg = 32'(s.idle_sh);
      hpt_pkg::A_BPER: rdreg = 32'(s.per_sh);
      hpt_pkg::A_BTRIG: rdreg = {1'b0, s.trg};
      hpt_pkg::A_BSTAT: rdreg = 32'(bs);
      hpt_pkg::A_BCNT: rdreg = 32'(s.cnt);
      default: rdreg = 32'h00000000;
    endcase
  endfunction

  // Byte-lane merge of write data over the current value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    logic [31:0] wd;
    logic wr;
    logic sw_trg;
    logic cal_go;
    logic tick;
    logic pend_end;
    logic xfer;
    logic idle_ph;
    logic open;
    logic win;
    logic [3:0] m;
    logic [5:0] e;
    logic [9:0] rise;
    hpt_pkg::hpt_evcfg_t cfg;
    hpt_pkg::hpt_bctl_t wbc;
    hpt_pkg::hpt_bstat_t wbs;
    hpt_pkg::hpt_dll_t wdl;
    st_next = st_reg;
    wd = merge(rdreg(st_reg, awaddr), wdata, wstrb);
    wr = st_reg.awready;
    sw_trg = 1'b0;
    cal_go = 1'b0;
    tick = 1'b0;
    pend_end = 1'b0;
    xfer = 1'b0;
    idle_ph = 1'b0;
    open = 1'b0;
    win = 1'b0;
    m = hpt_pkg::FM_OFF;
    e = '0;
    rise = burst_src_in & ~st_reg.sprev;
    cfg = '0;
    wbc = hpt_pkg::hpt_bctl_t'(wd[$bits(hpt_pkg::hpt_bctl_t)-1:0]);
    wbs = hpt_pkg::hpt_bstat_t'(wd[$bits(hpt_pkg::hpt_bstat_t)-1:0]);
    wdl = hpt_pkg::hpt_dll_t'(wd[$bits(hpt_pkg::hpt_dll_t)-1:0]);
    st_next.awready = 1'b0;
    st_next.wready = 1'b0;
    st_next.arready = 1'b0;
    st_next.evo = '0;
    st_next.tmo = '0;
    st_next.dac = '0;

    // Bus: take address and data together, answer the cycle after
    if (st_reg.bvalid && bready)
      st_next.bvalid = 1'b0;
    if (awvalid && wvalid && !st_reg.awready && !st_reg.bvalid)
    begin
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    if (st_reg.rvalid && rready)
      st_next.rvalid = 1'b0;
    if (arvalid && !st_reg.arready && !st_reg.rvalid)
      st_next.arready = 1'b1;
    if (st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rdreg(st_reg, araddr);
      st_next.rresp = mapped(araddr) ? hpt_pkg::RESP_OKAY : hpt_pkg::RESP_DECERR;
    end

    // Register writes come first so hardware sets below win over clears
    if (wr)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp = mapped(awaddr) ? hpt_pkg::RESP_OKAY : hpt_pkg::RESP_DECERR;
      case (awaddr)
        hpt_pkg::A_FILT_LO: st_next.evc[0] = hpt_pkg::hpt_evgrp_t'(wd[$bits(hpt_pkg::hpt_evgrp_t)-1:0]);
        hpt_pkg::A_FILT_HI: st_next.evc[1] = hpt_pkg::hpt_evgrp_t'(wd[$bits(hpt_pkg::hpt_evgrp_t)-1:0]);
        hpt_pkg::A_TCTL: st_next.tc = hpt_pkg::hpt_tctl_t'(wd[$bits(hpt_pkg::hpt_tctl_t)-1:0]);
        hpt_pkg::A_DLL:
        begin
          st_next.dl.periodic_cal_enable = wdl.periodic_cal_enable;
          st_next.dl.cal_interval_select = wdl.cal_interval_select;
          cal_go = wd[hpt_pkg::DLL_START_BIT] && !wdl.periodic_cal_enable;
        end
        hpt_pkg::A_BCTL:
        begin
          // Software can only clear the active flag, not set it
          st_next.bc = wbc;
          st_next.bc.burst_active_flag = st_reg.bc.burst_active_flag && wbc.burst_active_flag;
        end
        hpt_pkg::A_BIDLE:
        begin
          st_next.idle_sh = wd[CW-1:0];
          st_next.lock = 1'b0;
          if (!st_reg.bc.burst_preload_enable)
            st_next.idle_act = wd[CW-1:0];
        end
        hpt_pkg::A_BPER:
        begin
          st_next.per_sh = wd[CW-1:0];
          st_next.lock = st_reg.bc.burst_preload_enable;
          if (!st_reg.bc.burst_preload_enable)
            st_next.per_act = wd[CW-1:0];
        end
        hpt_pkg::A_BTRIG:
        begin
          st_next.trg = wd[30:0];
          sw_trg = wd[hpt_pkg::SOFT_BURST_TRIGGER_BIT];
        end
        hpt_pkg::A_BSTAT:
        begin
          st_next.ie = wbs.burst_period_irq_en;
          if (wbs.burst_period_flag_clr)
            st_next.pf = 1'b0;
        end
        default: st_next.bresp = hpt_pkg::RESP_DECERR;
      endcase
    end

    // Reset-to-compare interval of every sub-timer; a reset reopens it
    for (int t = 0; t < hpt_pkg::NTMR; t++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        if (cnt_rst[t])
          st_next.ivl[t][c] = 1'b1;
        else if (cmp_evt[t][c])
          st_next.ivl[t][c] = 1'b0;
      end
    end

    // Per-event filter
    for (int y = 0; y < NE; y++)
    begin
      cfg = st_reg.evc[y / hpt_pkg::NPG][y % hpt_pkg::NPG];
      m = cfg.event_filter_mode;
      win = 1'b0;
      e = '0;
      if (m <= hpt_pkg::FM_OWN_HI)
      begin
        open = (m == hpt_pkg::FM_OFF) || !st_reg.ivl[TIMER_ID][2'(m - 4'h1)];
      end
      else if (m <= hpt_pkg::FM_FOR_HI)
      begin
        e = hpt_pkg::BLANK_MAP[TIMER_ID][3'(m - hpt_pkg::FM_FOR_LO)];
        open = e[5] ? chan1_pre_output[e[4:2]] : !st_reg.ivl[e[4:2]][e[1:0]];
      end
      else
      begin
        if (m == hpt_pkg::FM_WIN_C1)
          win = st_reg.ivl[TIMER_ID][1];
        else if (m == hpt_pkg::FM_WIN_C2)
          win = st_reg.ivl[TIMER_ID][2];
        else
          win = st_reg.ivl[hpt_pkg::WIN_PARTNER[TIMER_ID]][1];
        open = win;
      end
      if (open)
      begin
        st_next.evo[y] = conditioned_ext_event[y] || st_reg.pend[y];
        st_next.pend[y] = 1'b0;
      end
      else if (conditioned_ext_event[y] && cfg.event_memorize_enable)
      begin
        st_next.pend[y] = 1'b1;
      end
      if (m > hpt_pkg::FM_FOR_HI)
      begin
        if (win && !st_reg.wprev[y])
          st_next.seen[y] = st_next.evo[y];
        else if (win && st_next.evo[y])
          st_next.seen[y] = 1'b1;
        st_next.tmo[y] = !win && st_reg.wprev[y] && !st_reg.seen[y];
      end
      st_next.wprev[y] = win;
    end

    if (update_evt && st_reg.tc.dac_request_select != 2'h0)
      st_next.dac[st_reg.tc.dac_request_select] = 1'b1;

    // Calibration sequencer; the delay line itself sits outside
    // calibration of 64x clock
    if (st_reg.dl.cal_busy)
    begin
      st_next.calc = st_reg.calc + CW'(1);
      if (st_reg.calc == CW'(CAL_LEN - 1))
      begin
        st_next.dl.cal_busy = 1'b0;
        st_next.dl.cal_ready = 1'b1;
      end
    end
    if (st_reg.dl.periodic_cal_enable && timer_run && !st_reg.dl.cal_busy)
    begin
      st_next.perc = st_reg.perc + CW'(1);
      if (st_reg.perc >= (CW'(CAL_BASE) << st_reg.dl.cal_interval_select) - CW'(1))
      begin
        st_next.perc = '0;
        cal_go = 1'b1;
      end
    end
    if (cal_go && !st_reg.dl.cal_busy)
    begin
      st_next.dl.cal_busy = 1'b1;
      st_next.calc = '0;
    end

    st_next.sprev = burst_src_in;
    st_next.psc = st_reg.psc + CW'(1);
    if (st_reg.psc >= (CW'(1) << st_reg.bc.burst_prescaler) - CW'(1))
    begin
      st_next.psc = '0;
      tick = st_reg.bc.burst_clock_select == hpt_pkg::BCLK_PSC;
    end
    if (st_reg.bc.burst_clock_select <= hpt_pkg::BCLK_INT_HI)
      tick = rise[st_reg.bc.burst_clock_select];

    // Burst counter; software clearing enable or active flag ends it
    if (st_reg.run && (!st_next.bc.burst_enable || !st_next.bc.burst_active_flag))
    begin
      st_next.run = 1'b0;
      st_next.entered = 1'b0;
    end
    else if (st_reg.run && tick)
    begin
      if (!st_reg.entered)
      begin
        st_next.entered = 1'b1;
      end
      else if (st_reg.cnt == st_reg.per_act)
      begin
        pend_end = 1'b1;
        st_next.cnt = '0;
        if (!st_reg.bc.burst_continuous)
        begin
          st_next.run = 1'b0;
          st_next.entered = 1'b0;
          st_next.bc.burst_active_flag = 1'b0;
        end
      end
      else
      begin
        st_next.cnt = st_reg.cnt + CW'(1);
      end
    end

    if ((|(st_reg.trg & burst_trig_in) || sw_trg) && st_reg.bc.burst_enable && !st_reg.run)
    begin
      st_next.run = 1'b1;
      st_next.entered = 1'b0;
      st_next.cnt = '0;
      st_next.bc.burst_active_flag = 1'b1;
    end

    if (pend_end)
      st_next.pf = 1'b1;
    st_next.irq = st_next.pf && st_next.ie;

    st_next.en_prev = st_reg.bc.burst_enable;
    xfer = pend_end || (st_reg.bc.burst_enable && !st_reg.en_prev);
    if (xfer && st_reg.bc.burst_preload_enable && !st_reg.lock)
    begin
      st_next.idle_act = st_reg.idle_sh;
      st_next.per_act = st_reg.per_sh;
    end

    idle_ph = st_reg.run && st_reg.entered && (st_reg.cnt < st_reg.idle_act);
    for (int i = 0; i < 2; i++)
    begin
      if (idle_ph && st_reg.tc.burst_idle_ctrl_en[i])
        st_next.pre[i] = st_reg.tc.idle_level_select[i];
      else
        st_next.pre[i] = chan_pre_output[i];
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset clears every field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Outputs straight from state flops
  assign awready = st_reg.awready;
  assign wready = st_reg.wready;
  assign bresp = st_reg.bresp;
  assign bvalid = st_reg.bvalid;
  assign arready = st_reg.arready;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign rvalid = st_reg.rvalid;
  assign filt_event_out = st_reg.evo;
  assign filt_timeout_out = st_reg.tmo;
  assign dac_request_out = st_reg.dac;
  assign dll_cal_active = st_reg.dl.cal_busy;
  assign burst_pre_output = st_reg.pre;
  assign burst_period_irq = st_reg.irq;
  assign burst_active = st_reg.bc.burst_active_flag;

endmodule // hpt_burst_ctrl

//--- logic/hpt_pkg.sv
package hpt_pkg;

  // ----------------------------------------
  // Register map and sizes
  // ----------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] A_FILT_LO = 8'h00;
  localparam logic [AW-1:0] A_FILT_HI = 8'h04;
  localparam logic [AW-1:0] A_TCTL = 8'h08;
  localparam logic [AW-1:0] A_DLL = 8'h0C;
  localparam logic [AW-1:0] A_BCTL = 8'h10;
  localparam logic [AW-1:0] A_BIDLE = 8'h14;
  localparam logic [AW-1:0] A_BPER = 8'h18;
  localparam logic [AW-1:0] A_BTRIG = 8'h1C;
  localparam logic [AW-1:0] A_BSTAT = 8'h20;
  localparam logic [AW-1:0] A_BCNT = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int NEVT = 10;
  localparam int NPG = 5;
  localparam int NTMR = 5;
  localparam int CW = 16;
  localparam int SOFT_BURST_TRIGGER_BIT = 31;
  localparam int DLL_START_BIT = 5;
  localparam logic [6:0] HPCK_MULT = 7'h40;

  // ----------------------------------------
  // Filter and clock select codes
  // ----------------------------------------
  localparam logic [3:0] FM_OFF = 4'h0;
  localparam logic [3:0] FM_OWN_HI = 4'h4;
  localparam logic [3:0] FM_FOR_LO = 4'h5;
  localparam logic [3:0] FM_FOR_HI = 4'hC;
  localparam logic [3:0] FM_WIN_C1 = 4'hD;
  localparam logic [3:0] FM_WIN_C2 = 4'hE;
  localparam logic [3:0] BCLK_INT_HI = 4'h9;
  localparam logic [3:0] BCLK_PSC = 4'hA;

  // Foreign blanking table: {chan1 level, timer[2:0], compare[1:0]}
  localparam logic [5:0] BLANK_MAP [NTMR][8] = '{
    '{6'h04, 6'h07, 6'h24, 6'h08, 6'h0B, 6'h28, 6'h0C, 6'h11},
    '{6'h00, 6'h03, 6'h20, 6'h08, 6'h09, 6'h28, 6'h0D, 6'h10},
    '{6'h01, 6'h04, 6'h07, 6'h24, 6'h0C, 6'h0F, 6'h2C, 6'h13},
    '{6'h00, 6'h05, 6'h08, 6'h09, 6'h28, 6'h10, 6'h13, 6'h30},
    '{6'h01, 6'h04, 6'h08, 6'h0B, 6'h28, 6'h0C, 6'h0F, 6'h2C}};
  localparam logic [2:0] WIN_PARTNER [NTMR] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h3};

  // ----------------------------------------
  // Register field layouts
  // ----------------------------------------
  typedef struct packed {
    logic event_memorize_enable;
    logic [3:0] event_filter_mode;
  } hpt_evcfg_t;
  typedef hpt_evcfg_t [NPG-1:0] hpt_evgrp_t;

  typedef struct packed {
    logic [1:0] idle_level_select;
    logic [1:0] burst_idle_ctrl_en;
    logic [1:0] dac_request_select;
  } hpt_tctl_t;

  typedef struct packed {
    logic cal_ready;
    logic cal_busy;
    logic [1:0] cal_interval_select;
    logic periodic_cal_enable;
  } hpt_dll_t;

  typedef struct packed {
    logic burst_preload_enable;
    logic [3:0] burst_prescaler;
    logic [3:0] burst_clock_select;
    logic burst_active_flag;
    logic burst_continuous;
    logic burst_enable;
  } hpt_bctl_t;

  typedef struct packed {
    logic burst_period_irq_en;
    logic burst_period_flag_clr;
    logic burst_period_flag;
  } hpt_bstat_t;

endpackage

//--- test/hpt_burst_ctrl_monitor.sv
`timescale 1ns/100ps
// ------
// Port checker
// ------
module hpt_burst_ctrl_monitor #(
  parameter int CAL_LEN = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic update_evt,
  input wire logic [3:0] dac_request_out,
  input wire logic dll_cal_active,
  input wire logic [1:0] chan_pre_output,
  input wire logic [1:0] burst_pre_output,
  input wire logic burst_active,
  input wire logic [hpt_pkg::NEVT-1:0] filt_timeout_out
);
  int cal_n;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Length of the current calibration run
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !dll_cal_active)
      cal_n <= 0;
    else
      cal_n <= cal_n + 1;
  end
  property p_dac_sel; $onehot0(dac_request_out) && !dac_request_out[0]; endproperty
  a_dac_sel: assert property (p_dac_sel) else $error("dac request on wrong lines");
  property p_dac_cause; dac_request_out != 4'h0 |-> $past(update_evt); endproperty
  a_dac_cause: assert property (p_dac_cause) else $error("dac request without update");
  sequence s_quiet; !burst_active [*3]; endsequence
  property p_pass; s_quiet |-> burst_pre_output == $past(chan_pre_output); endproperty
  a_pass: assert property (p_pass) else $error("pre-output altered outside burst");
  // A run lasts exactly the configured number of cycles
  property p_cal; $fell(dll_cal_active) |-> cal_n == CAL_LEN; endproperty
  a_cal: assert property (p_cal) else $error("calibration run length wrong");
  property p_aw; awready |-> wready ##1 !awready; endproperty
  a_aw: assert property (p_aw) else $error("write ready not a joint pulse");
  property p_b; awready |=> bvalid; endproperty
  a_b: assert property (p_b) else $error("write response late");
  property p_bdrop; bvalid && bready |=> !bvalid; endproperty
  a_bdrop: assert property (p_bdrop) else $error("write response not released");
  property p_r; arready |=> rvalid; endproperty
  a_r: assert property (p_r) else $error("read data late");
  property p_rdrop; rvalid && rready |=> !rvalid; endproperty
  a_rdrop: assert property (p_rdrop) else $error("read data not released");
  c_dac: cover property (dac_request_out != 4'h0);
  c_burst: cover property ($rose(burst_active));
  c_to: cover property (filt_timeout_out != '0);
  c_cal: cover property ($fell(dll_cal_active));
endmodule // hpt_burst_ctrl_monitor
bind hpt_burst_ctrl hpt_burst_ctrl_monitor #(.CAL_LEN(CAL_LEN)) u_hpt_burst_ctrl_monitor (.aclk, .aresetn, .awready,
  .wready, .bvalid, .bready, .arready, .rvalid, .rready, .update_evt, .dac_request_out, .dll_cal_active,
  .chan_pre_output, .burst_pre_output, .burst_active, .filt_timeout_out);

//--- test/hpt_burst_ctrl_test.sv
`timescale 1ns/100ps
// ------
// Register level bench
// ------
module hpt_burst_ctrl_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, timer_run, update_evt, awready, wready;
  logic bvalid, arready, rvalid, dll_cal_active, burst_period_irq, burst_active;
  logic [hpt_pkg::AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, e;
  logic [1:0] bresp, rresp, r, chan_pre_output, burst_pre_output;
  logic [3:0] dac_request_out;
  logic [30:0] burst_trig_in;
  logic [9:0] burst_src_in;
  logic [hpt_pkg::NTMR-1:0] cnt_rst, chan1_pre_output;
  logic [hpt_pkg::NTMR-1:0][3:0] cmp_evt;
  logic [hpt_pkg::NEVT-1:0] conditioned_ext_event, filt_event_out, filt_timeout_out;
  int miscompares, total_checks, w, act, n [6];
  // Filter cases: mode byte, counter phase, events, timeouts
  logic [31:0] tab [11] = '{32'h00020100, 32'h01020000, 32'h01140100, 32'h11020100, 32'h05020000,
    32'h07140000, 32'h07080100, 32'h0D030100, 32'h0D140001, 32'h0E0A0100, 32'h0F140001};
  hpt_burst_ctrl #(.CAL_LEN(6), .CAL_BASE(8)) u_hpt_burst_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .timer_run, .cnt_rst, .cmp_evt, .chan1_pre_output, .conditioned_ext_event, .update_evt,
    .burst_trig_in, .burst_src_in, .chan_pre_output, .filt_event_out, .filt_timeout_out,
    .dac_request_out, .dll_cal_active, .burst_pre_output, .burst_period_irq, .burst_active);
  hpt_far_model u_hpt_far_model (.aclk, .aresetn, .cnt_rst, .cmp_evt, .chan1_pre_output);
  // Free-running source count; bit k rises every 2^(k+1) cycles, zero in reset to avoid a false edge
  always @(posedge aclk)
    burst_src_in <= aresetn ? burst_src_in + 10'h001 : 10'h000;
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    w = 0;
    do begin @(posedge aclk); w++; end while (awready !== 1'b1 && w < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge aclk); w++; end while (bvalid !== 1'b1 && w < 50);
    chk("bus_wait", 32'h1, 32'(w < 50));
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    w = 0;
    do begin @(posedge aclk); w++; end while (arready !== 1'b1 && w < 50);
    arvalid <= 1'b0;
    do begin @(posedge aclk); w++; end while (rvalid !== 1'b1 && w < 50);
    chk("bus_wait", 32'h1, 32'(w < 50));
    d = rdata;
    r = rresp;
  endtask
  // Counts rising edges of the watched outputs
  task watch(input int cyc);
    logic [5:0] v;
    logic [5:0] p;
    n = '{default: 0};
    act = 0;
    p = 6'h20;
    repeat (cyc)
    begin
      @(posedge aclk);
      v = {!burst_active, burst_active, dll_cal_active, burst_pre_output == 2'b10, filt_timeout_out[0],
        filt_event_out[0]};
      act += int'(burst_active);
      for (int k = 0; k < 6; k++)
        n[k] += (v[k] && !p[k]) ? 1 : 0;
      p = v;
    end
  endtask
  // One-cycle pulse on trigger input 0, then watch
  task hw_burst(input int cyc);
    burst_trig_in[0] <= 1'b1;
    @(posedge aclk);
    burst_trig_in[0] <= 1'b0;
    watch(cyc);
  endtask
  task summarize;
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Hang guard, far beyond the planned run
  initial
  begin
    #100000;
    miscompares++;
    summarize();
  end
  initial
  begin
    {awvalid, wvalid, arvalid, timer_run, update_evt, aresetn, awaddr, araddr, wdata} = '0;
    {bready, rready, chan_pre_output, burst_trig_in, conditioned_ext_event} = {4'hD, 41'h0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(hpt_pkg::A_DLL);
    chk("dll", 32'h00004000, d);
    rd(8'h40);
    chk("unmapped", {30'h0, hpt_pkg::RESP_DECERR}, {d[29:0], r});
    // Every select value, zero included
    for (int s = 0; s < 4; s++)
    begin
      wr(hpt_pkg::A_TCTL, 32'(s));
      update_evt <= 1'b1;
      @(posedge aclk);
      update_evt <= 1'b0;
      @(posedge aclk);
      chk("dac", (s == 0) ? 32'h0 : 32'(1 << s), {28'h0, dac_request_out});
    end
    for (int i = 0; i < 11; i++)
    begin
      e = tab[i];
      wr(hpt_pkg::A_FILT_LO, {24'h0, e[31:24]});
      while (u_hpt_far_model.cnt_reg !== e[20:16] && w < 200) begin @(posedge aclk); w++; end
      conditioned_ext_event[0] <= 1'b1;
      @(posedge aclk);
      conditioned_ext_event[0] <= 1'b0;
      watch(28);
      chk("filt_event", {24'h0, e[15:8]}, 32'(n[0]));
      chk("filt_timeout", {24'h0, e[7:0]}, 32'(n[1]));
    end
    wr(hpt_pkg::A_DLL, 32'h20);
    watch(20);
    chk("cal_once", 32'h1, 32'(n[3]));
    timer_run <= 1'b1;
    wr(hpt_pkg::A_DLL, 32'h1);
    watch(100);
    chk("cal_repeat", 32'h1, 32'(n[3] >= 2));
    wr(hpt_pkg::A_DLL, 32'h0);
    // Period before idle compare so the load is not held back
    wr(hpt_pkg::A_BPER, 32'h3);
    wr(hpt_pkg::A_BIDLE, 32'h1);
    wr(hpt_pkg::A_TCTL, 32'h2C);
    wr(hpt_pkg::A_BSTAT, 32'h4);
    wr(hpt_pkg::A_BCTL, 32'h51);
    wr(hpt_pkg::A_BTRIG, 32'h80000000);
    watch(40);
    chk("soft_start", 32'h1, 32'(n[4]));
    chk("idle_level", 32'h1, 32'(n[2] > 0));
    chk("single_stop", 32'h1, 32'(n[5]));
    chk("irq", 32'h1, {31'h0, burst_period_irq});
    rd(hpt_pkg::A_BSTAT);
    chk("period_flag", 32'h1, {31'h0, d[0]});
    wr(hpt_pkg::A_BSTAT, 32'h6);
    watch(2);
    chk("irq_clear", 32'h0, {31'h0, burst_period_irq});
    wr(hpt_pkg::A_BTRIG, 32'h1);
    wr(hpt_pkg::A_BCTL, 32'h53);
    hw_burst(40);
    chk("hw_start", 32'h1, 32'(n[4]));
    chk("continuous", 32'h0, 32'(n[5]));
    chk("irq_again", 32'h1, {31'h0, burst_period_irq});
    wr(hpt_pkg::A_BCTL, 32'h51);
    watch(4);
    chk("sw_stop", 32'h0, {31'h0, burst_active});
    // Preload on: a lone period write must not reach the active copy
    wr(hpt_pkg::A_BCTL, 32'h850);
    wr(hpt_pkg::A_BPER, 32'h5);
    wr(hpt_pkg::A_BCTL, 32'h851);
    hw_burst(20);
    chk("held_period", 32'h5, 32'(act));
    // Idle write releases the load; re-enable moves both copies
    wr(hpt_pkg::A_BIDLE, 32'h1);
    wr(hpt_pkg::A_BCTL, 32'h850);
    wr(hpt_pkg::A_BCTL, 32'h851);
    hw_burst(20);
    chk("loaded_period", 32'h7, 32'(act));
    // Internal source six counts once per 128 cycles, seven counts end the run
    wr(hpt_pkg::A_BCTL, 32'h831);
    hw_burst(600);
    chk("slow_clock_run", 32'h0, 32'(n[5]));
    watch(400);
    chk("slow_clock_end", 32'h1, 32'(n[5]));
    summarize();
  end
endmodule // hpt_burst_ctrl_test

//--- test/hpt_far_model.sv
`timescale 1ns/100ps
// ------
// Sibling timer stand-in
// ------
module hpt_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [hpt_pkg::NTMR-1:0] cnt_rst,
  output logic [hpt_pkg::NTMR-1:0][3:0] cmp_evt,
  output logic [hpt_pkg::NTMR-1:0] chan1_pre_output
);
  logic [4:0] cnt_reg;
  // Shared 32-cycle period so every span is known to the bench
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= 5'h00;
    else
      cnt_reg <= cnt_reg + 5'h01;
  end
  // foreign blanking sources
  // Reset at 0, compare k at 4k+4, chan1 high in first half
  always_comb
  begin
    for (int t = 0; t < hpt_pkg::NTMR; t++)
    begin
      cnt_rst[t] = (cnt_reg == 5'h00);
      chan1_pre_output[t] = (cnt_reg < 5'h10);
      for (int k = 0; k < 4; k++)
        cmp_evt[t][k] = (cnt_reg == 5'(4 * k + 4));
    end
  end
endmodule // hpt_far_model
